// file: logic/cspl_top.sv
// serial port pin logic of the codec: framing, shifting, strobes, control bits
`timescale 1ns/1ps
`default_nettype none

// What this block does
// RULE_01: control bit selects auxiliary or main input
// RULE_02: dual-word: secondary input sent during secondary frame
// RULE_03: dual-word only: secondary sync, general outputs driven
// RULE_04: strap high gives word/byte; pin selects format
// RULE_05: word/byte only: format input and end strobes
// RULE_06: converter bits shifted out on bit clock
// RULE_07: processor bits captured on the bit clock
// RULE_08: dual-word: general output a follows bit a
// RULE_09: reset clears control bit a, output low
// RULE_10: general output a changes right on write
// RULE_11: word mode: transmit strobe pulses after 16
// RULE_12: byte mode: transmit strobe low between bytes
// RULE_13: secondary sync low for sixteen bit clocks
// RULE_14: general output b follows bit b, resets low
// RULE_15: receive strobe: pulse word, held between bytes
// RULE_16: receive sync low while converter bits shift
// RULE_17: processor keeps input stable, samples same clock

module cspl_top (
  input  wire logic                    clock_i,                    // system clock, 20 MHz
  input  wire logic                    nrst_i,                     // asynchronous reset, active low
  input  wire logic                    shift_clk_i,                // serial bit clock, sampled
  input  wire logic                    serial_data_in_i,           // bits from the processor
  input  wire logic                    mode_strap_i,               // high: word/byte, low: dual-word
  input  wire logic                    word_byte_i,                // shared pin read: high word, low byte
  input  wire logic                    secondary_data_input_i,     // level sent in dual-word secondary frames
  input  wire logic [cspl_pkg::WORD_W-1:0] adc_data_i,             // converter word to send
  input  wire logic                    adc_valid_i,                // converter word offered
  output logic                         adc_ready_o,                // buffer has room
  output logic                         serial_data_out_o,          // bits to the processor
  output logic                         receive_frame_sync_o,       // low while converter bits shift
  output logic                         transmit_frame_sync_o,      // low while input bits are taken
  output logic                         secondary_frame_sync_o,     // shared pin drive, low in dual-word secondary frames
  output logic                         secondary_frame_sync_oe_o,  // high while the shared pin is driven
  output logic                         general_output_a_o,         // control bit a in dual-word mode
  output logic                         general_output_b_o,         // control bit b in dual-word mode
  output logic                         transmit_end_strobe_n_o,    // end of input transfer, active low
  output logic                         receive_end_strobe_n_o,     // end of output transfer, active low
  output logic                         aux_input_select_o,         // high: auxiliary input pair in use
  output logic [cspl_pkg::WORD_W-1:0]  dac_data_o,                 // data word received
  output logic                         dac_valid_o                 // one-cycle pulse with dac_data_o
);
  import cspl_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [4:0]        pin_s;              // synchronised pin levels
  logic              sclk_s;             // bit clock level
  logic              dx_s;               // serial input level
  logic              strap_s;            // mode strap level
  logic              wb_s;               // word/byte select level
  logic              sec_s;              // secondary data level
  logic              sclk_d_ff;          // bit clock one cycle ago
  logic              sclk_rise;          // bit clock rising edge seen
  logic              sclk_fall;          // bit clock falling edge seen
  logic              dual_mode;          // dual-word mode
  logic              byte_mode;          // byte format in word/byte mode
  cspl_state_t       state_ff;           // sequencer state
  cspl_state_t       nxt_state;          // sequencer state after this edge
  logic [CNT_W-1:0]  bit_cnt_ff;         // bits taken in this frame
  logic [CNT_W-1:0]  flen;               // bits in this frame
  logic              frm_byte_ff;        // current primary word uses bytes
  logic              half_ff;            // first byte done, second owed
  logic              sec_pend_ff;        // a secondary frame is owed
  logic              pop;                // take a word from the buffer
  logic              frame_end;          // last bit of the frame taken
  logic              word_done;          // a whole input word is in
  logic [WORD_W-1:0] tx_sh_ff;           // outgoing shift register
  logic [WORD_W-1:0] rx_sh_ff;           // incoming shift register
  logic [WORD_W-1:0] rx_word;            // incoming word with the last bit
  logic              buf_valid;          // buffer holds a word
  logic [WORD_W-1:0] buf_data;           // oldest buffered word
  logic              ctrl_a_ff;          // control bit a
  logic              ctrl_b_ff;          // control bit b
  logic              ctrl_aux_ff;        // auxiliary select bit
  logic              nxt_ctrl_a;         // control bit a after this edge
  logic              nxt_ctrl_b;         // control bit b after this edge
  logic              nxt_ctrl_aux;       // auxiliary select after this edge
  logic              eod_pulse_ff;       // strobe low is a word-mode pulse

  // ----------------------------------------------------------------
  // pin synchronisers and bit clock edges
  // ----------------------------------------------------------------
  cspl_sync #(
    .W (5)
  ) u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .async_i ({shift_clk_i, serial_data_in_i, mode_strap_i, word_byte_i, secondary_data_input_i}),
    .sync_o  (pin_s)
  );

  assign sclk_s = pin_s[4];
  assign dx_s   = pin_s[3];
  assign strap_s = pin_s[2];
  assign wb_s   = pin_s[1];
  assign sec_s  = pin_s[0];

  // the strap low means dual-word; high hands the shared pin to format select
  assign dual_mode = ~strap_s;           // RULE_04
  assign byte_mode = strap_s & ~wb_s;    // RULE_04

  // edge finder on the synchronised clock; the bit clock is far slower than ours
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sclk_d_ff <= 1'b0;
    end else begin
      sclk_d_ff <= sclk_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d_ff;
  assign sclk_fall = ~sclk_s & sclk_d_ff;

  // ----------------------------------------------------------------
  // converter word buffer; a slow link stalls the source, no loss
  // ----------------------------------------------------------------
  cspl_buf2 #(
    .W     (WORD_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clock_i     (clock_i),
    .nrst_i      (nrst_i),
    .in_data_i   (adc_data_i),
    .in_valid_i  (adc_valid_i),
    .in_ready_o  (adc_ready_o),
    .out_data_o  (buf_data),
    .out_valid_o (buf_valid),
    .out_ready_i (pop)
  );

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  // secondary frames are always a full word; primary ones follow the format
  assign flen      = (frm_byte_ff && state_ff == CSPL_PRIM) ? BYTE_BITS : WORD_BITS;  // RULE_13
  assign frame_end = sclk_fall && (state_ff != CSPL_IDLE) && (bit_cnt_ff == flen - CNT_W'(1));
  assign word_done = frame_end && ((state_ff == CSPL_SEC) || !frm_byte_ff || half_ff);
  assign rx_word   = {rx_sh_ff[WORD_W-2:0], dx_s};

  // frames open on a rising bit clock edge and close on a falling one
  always_comb begin
    nxt_state = state_ff;
    pop       = 1'b0;
    case (state_ff)
      CSPL_IDLE: begin
        if (sclk_rise) begin
          if (sec_pend_ff) begin
            nxt_state = CSPL_SEC;
          end else if (half_ff) begin
            nxt_state = CSPL_PRIM;
          end else if (buf_valid) begin
            nxt_state = CSPL_PRIM;
            pop       = 1'b1;
          end
        end
      end
      CSPL_PRIM, CSPL_SEC: begin
        if (frame_end) begin
          nxt_state = CSPL_IDLE;
        end
      end
      default: begin
        nxt_state = CSPL_IDLE;
      end
    endcase
  end

  // state, bit count, format and pending flags
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff    <= CSPL_IDLE;
      bit_cnt_ff  <= '0;
      frm_byte_ff <= 1'b0;
      half_ff     <= 1'b0;
      sec_pend_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == CSPL_IDLE && nxt_state != CSPL_IDLE) begin
        bit_cnt_ff <= '0;
      end else if (sclk_fall && state_ff != CSPL_IDLE) begin
        bit_cnt_ff <= bit_cnt_ff + CNT_W'(1);
      end
      // format is frozen per word so a pin change cannot split a word oddly
      if (pop) begin
        frm_byte_ff <= byte_mode;
      end
      if (frame_end && state_ff == CSPL_PRIM && frm_byte_ff) begin
        half_ff <= ~half_ff;
      end
      // a primary word ending in the request code asks for a control word
      if (word_done && state_ff == CSPL_PRIM && rx_word[1:0] == SEC_REQ_CODE) begin
        sec_pend_ff <= 1'b1;
      end else if (state_ff == CSPL_IDLE && nxt_state == CSPL_SEC) begin
        sec_pend_ff <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outgoing bits: msb is on the pin as the frame opens
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_sh_ff          <= '0;
      serial_data_out_o <= 1'b0;
    end else begin
      if (pop) begin
        tx_sh_ff          <= buf_data;             // RULE_06
        serial_data_out_o <= buf_data[WORD_W-1];   // RULE_06
      end else if (sclk_rise && nxt_state == CSPL_PRIM) begin
        tx_sh_ff          <= {tx_sh_ff[WORD_W-2:0], 1'b0};  // RULE_06
        serial_data_out_o <= tx_sh_ff[WORD_W-2];            // RULE_06
      end else if (sclk_rise && nxt_state == CSPL_SEC) begin
        serial_data_out_o <= dual_mode & sec_s;    // RULE_02
      end
    end
  end

  // ----------------------------------------------------------------
  // incoming bits: taken on the falling edge, mid-bit for the processor
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rx_sh_ff    <= '0;
      dac_data_o  <= '0;
      dac_valid_o <= 1'b0;
    end else begin
      if (sclk_fall && state_ff != CSPL_IDLE) begin
        rx_sh_ff <= rx_word;                       // RULE_07 RULE_17
      end
      dac_valid_o <= word_done && (state_ff == CSPL_PRIM);
      if (word_done && state_ff == CSPL_PRIM) begin
        dac_data_o <= rx_word;                     // RULE_07
      end
    end
  end

  // ----------------------------------------------------------------
  // control bits: loaded from a finished secondary word
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ctrl_a   = ctrl_a_ff;
    nxt_ctrl_b   = ctrl_b_ff;
    nxt_ctrl_aux = ctrl_aux_ff;
    if (word_done && state_ff == CSPL_SEC) begin
      nxt_ctrl_a   = rx_word[CTRL_A_POS];
      nxt_ctrl_b   = rx_word[CTRL_B_POS];
      nxt_ctrl_aux = rx_word[CTRL_AUX_POS];
    end
  end

  // pins load from the next value so they move on the same edge as the bits
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_a_ff          <= CTRL_A_RST;            // RULE_09
      ctrl_b_ff          <= CTRL_B_RST;            // RULE_14
      ctrl_aux_ff        <= CTRL_AUX_RST;
      general_output_a_o <= 1'b0;                  // RULE_09
      general_output_b_o <= 1'b0;                  // RULE_14
      aux_input_select_o <= 1'b0;
    end else begin
      ctrl_a_ff          <= nxt_ctrl_a;
      ctrl_b_ff          <= nxt_ctrl_b;
      ctrl_aux_ff        <= nxt_ctrl_aux;
      general_output_a_o <= dual_mode & nxt_ctrl_a;  // RULE_03 RULE_08 RULE_10
      general_output_b_o <= dual_mode & nxt_ctrl_b;  // RULE_03 RULE_14
      aux_input_select_o <= nxt_ctrl_aux;            // RULE_01
    end
  end

  // ----------------------------------------------------------------
  // frame syncs, shared pin drive
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      receive_frame_sync_o      <= 1'b1;
      transmit_frame_sync_o     <= 1'b1;
      secondary_frame_sync_o    <= 1'b1;
      secondary_frame_sync_oe_o <= 1'b0;
    end else begin
      receive_frame_sync_o      <= (nxt_state != CSPL_PRIM);                 // RULE_16
      transmit_frame_sync_o     <= (nxt_state == CSPL_IDLE);                 // RULE_07
      secondary_frame_sync_o    <= !(dual_mode && nxt_state == CSPL_SEC);    // RULE_02 RULE_13
      // word/byte mode releases the pin so it can be read as format select
      secondary_frame_sync_oe_o <= dual_mode;                                // RULE_03 RULE_05
    end
  end

  // ----------------------------------------------------------------
  // end-of-transfer strobes, word/byte mode only
  // ----------------------------------------------------------------
  // input and output frames share timing, so both strobes move together;
  // a word pulse lasts until the next rising bit clock edge
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      transmit_end_strobe_n_o <= 1'b1;
      receive_end_strobe_n_o  <= 1'b1;
      eod_pulse_ff            <= 1'b0;
    end else if (dual_mode) begin
      transmit_end_strobe_n_o <= 1'b1;             // RULE_05
      receive_end_strobe_n_o  <= 1'b1;             // RULE_05
      eod_pulse_ff            <= 1'b0;
    end else if (frame_end && state_ff == CSPL_PRIM) begin
      if (frm_byte_ff && !half_ff) begin
        transmit_end_strobe_n_o <= 1'b0;           // RULE_12
        receive_end_strobe_n_o  <= 1'b0;           // RULE_15
        eod_pulse_ff            <= 1'b0;
      end else if (frm_byte_ff) begin
        transmit_end_strobe_n_o <= 1'b1;           // RULE_12
        receive_end_strobe_n_o  <= 1'b1;           // RULE_15
      end else begin
        transmit_end_strobe_n_o <= 1'b0;           // RULE_11
        receive_end_strobe_n_o  <= 1'b0;           // RULE_15
        eod_pulse_ff            <= 1'b1;
      end
    end else if (sclk_rise && eod_pulse_ff) begin
      transmit_end_strobe_n_o <= 1'b1;             // RULE_11
      receive_end_strobe_n_o  <= 1'b1;             // RULE_15
      eod_pulse_ff            <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// file: inc/cspl_pkg.sv
// constants and types shared by the codec serial port pin logic
package cspl_pkg;

  // ----------------------------------------------------------------
  // word and frame geometry
  // ----------------------------------------------------------------
  localparam int         WORD_W       = 16;      // converter and control word width
  localparam int         CNT_W        = 5;       // bit counter width
  localparam logic [4:0] WORD_BITS    = 5'h10;   // bits in a word frame
  localparam logic [4:0] BYTE_BITS    = 5'h08;   // bits in a byte frame
  localparam int         BUF_DEPTH    = 2;       // entries in the converter word buffer

  // ----------------------------------------------------------------
  // control word layout
  // ----------------------------------------------------------------
  localparam int         CTRL_A_POS   = 10;      // drives general output a
  localparam int         CTRL_B_POS   = 11;      // drives general output b
  localparam int         CTRL_AUX_POS = 4;       // selects the auxiliary input pair
  localparam logic [1:0] SEC_REQ_CODE = 2'h3;    // low bits of a primary word asking for a control word
  localparam logic       CTRL_A_RST   = 1'b0;    // reset value of control bit a
  localparam logic       CTRL_B_RST   = 1'b0;    // reset value of control bit b
  localparam logic       CTRL_AUX_RST = 1'b0;    // reset value of the auxiliary select

  // ----------------------------------------------------------------
  // sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    CSPL_IDLE = 2'b00,   // between frames
    CSPL_PRIM = 2'b01,   // primary frame: converter data out, data word in
    CSPL_SEC  = 2'b10    // secondary frame: secondary data out, control word in
  } cspl_state_t;

endpackage

// file: logic/cspl_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
`default_nettype none

module cspl_sync #(
  parameter int W = 1                    // number of independent levels
) (
  input  wire logic         clock_i,     // system clock
  input  wire logic         nrst_i,      // asynchronous reset, active low
  input  wire logic [W-1:0] async_i,     // levels from outside the clock domain
  output logic      [W-1:0] sync_o       // levels safe to use
);

  logic [W-1:0] meta_ff;                 // first stage, read only by the second
  logic [W-1:0] sync_ff;                 // second stage

  // ----------------------------------------------------------------
  // two stages, reset to low
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_i;
      sync_ff <= meta_ff;
    end
  end

  assign sync_o = sync_ff;

endmodule

`default_nettype wire

// file: logic/cspl_buf2.sv
// small fifo with valid and ready on both sides, registered flags
`timescale 1ns/1ps
`default_nettype none

module cspl_buf2 #(
  parameter int W     = 16,              // word width
  parameter int DEPTH = 2                // entries, a power of two
) (
  input  wire logic         clock_i,     // system clock
  input  wire logic         nrst_i,      // asynchronous reset, active low
  input  wire logic [W-1:0] in_data_i,   // word offered by the source
  input  wire logic         in_valid_i,  // source has a word
  output logic              in_ready_o,  // room for a word, from a flip-flop
  output logic      [W-1:0] out_data_o,  // oldest word
  output logic              out_valid_o, // a word is held, from a flip-flop
  input  wire logic         out_ready_i  // drain takes the word
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem [DEPTH];            // storage
  logic [PW-1:0] wr_ptr_ff;              // next slot to fill
  logic [PW-1:0] rd_ptr_ff;              // next slot to drain
  logic [CW-1:0] count_ff;               // words held
  logic [CW-1:0] nxt_count;              // words held after this edge
  logic          room_ff;                // room left
  logic          held_ff;                // word held
  logic          push;                   // a word enters
  logic          pop;                    // a word leaves

  assign push = in_valid_i & room_ff;
  assign pop  = out_ready_i & held_ff;

  // ----------------------------------------------------------------
  // occupancy
  // ----------------------------------------------------------------
  always_comb begin
    nxt_count = count_ff;
    if (push && !pop) begin
      nxt_count = count_ff + CW'(1);
    end else if (pop && !push) begin
      nxt_count = count_ff - CW'(1);
    end
  end

  // flags are registered so the ports come straight from flip-flops
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count_ff <= '0;
      room_ff  <= 1'b1;
      held_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      room_ff  <= (nxt_count != CW'(DEPTH));
      held_ff  <= (nxt_count != '0);
    end
  end

  // ----------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + PW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + PW'(1);
      end
    end
  end

  // storage has no reset; held_ff keeps stale words unseen
  always_ff @(posedge clock_i) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_i;
    end
  end

  assign in_ready_o  = room_ff;
  assign out_valid_o = held_ff;
  assign out_data_o  = mem[rd_ptr_ff];

endmodule

`default_nettype wire

// file: verif/cspl_top_assertions.sv
// checker of frame, strobe and control pin relations
`timescale 1ns/1ps
`default_nettype none
module cspl_chk (
  input wire logic clock_i, nrst_i, shift_clk_i, dac_valid_o,
  input wire logic receive_frame_sync_o, transmit_frame_sync_o, secondary_frame_sync_o,
  input wire logic secondary_frame_sync_oe_o, general_output_a_o, general_output_b_o,
  input wire logic transmit_end_strobe_n_o, receive_end_strobe_n_o
);
  logic       sh_ff;  // last sampled bit clock level
  logic [4:0] sc_ff;  // raw bit clock falls in one secondary frame
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) sh_ff <= 1'b0;
    else sh_ff <= shift_clk_i;
  end
  // raw pin falls, so no synchroniser is shared with the design
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) sc_ff <= 5'h00;
    else if (secondary_frame_sync_o) sc_ff <= 5'h00;
    else if (sh_ff && !shift_clk_i) sc_ff <= sc_ff + 5'h01;
  end
  sequence s_close;
    $rose(receive_frame_sync_o) ##1 !dac_valid_o;
  endsequence
  a_sec_len: assert property ($rose(secondary_frame_sync_o) |-> sc_ff == 5'h10)
    else $error("secondary frame length wrong");
  a_sec_prim: assert property (!receive_frame_sync_o |-> secondary_frame_sync_o)
    else $error("secondary sync low in primary frame");
  a_sec_tx_pair: assert property (!secondary_frame_sync_o |-> !transmit_frame_sync_o)
    else $error("secondary sync without transmit sync");
  a_prim_tx_pair: assert property (!receive_frame_sync_o |-> !transmit_frame_sync_o)
    else $error("receive sync without transmit sync");
  a_word_close: assert property (dac_valid_o |-> s_close)
    else $error("data word not at frame close");
  a_gen_dual: assert property ((general_output_a_o || general_output_b_o) |-> secondary_frame_sync_oe_o)
    else $error("general output outside dual mode");
  a_strobe_mode: assert property (!transmit_end_strobe_n_o |-> !secondary_frame_sync_oe_o)
    else $error("end strobe in dual mode");
  a_strobe_pair: assert property (transmit_end_strobe_n_o == receive_end_strobe_n_o)
    else $error("end strobes differ");
  a_strobe_at_end: assert property ($fell(transmit_end_strobe_n_o) |-> $rose(transmit_frame_sync_o))
    else $error("end strobe not at frame end");
endmodule
bind cspl_top cspl_chk i_cspl_chk (.*);
`default_nettype wire

// file: verif/cspl_dsp_model.sv
// processor serial port model: bit clock, data in, capture of data out
`timescale 1ns/1ps
`default_nettype none
module cspl_dsp_model (
  input  wire logic [15:0] tx_word_i,
  input  wire logic        transmit_frame_sync_i,
  input  wire logic        serial_data_out_i,
  output logic             shift_clk_o,
  output logic             serial_data_in_o,
  output logic      [15:0] rx_word_o
);
  logic [3:0] idx = 4'h0;  // bits taken so far, wraps each word
  // bit clock runs free, odd phase keeps its edges off the system clock
  initial begin
    shift_clk_o = 1'b0;
    #13;
    forever #200 shift_clk_o = ~shift_clk_o;
  end
  initial serial_data_in_o = 1'b0;
  initial rx_word_o = 16'h0000;
  // device samples on the fall, so the next bit goes out on the rise
  always @(posedge shift_clk_o) serial_data_in_o <= tx_word_i[4'hf - idx];
  always @(negedge shift_clk_o) begin
    if (!transmit_frame_sync_i) begin
      idx <= idx + 4'h1;
      rx_word_o <= {rx_word_o[14:0], serial_data_out_i};
    end
  end
endmodule
`default_nettype wire

// file: verif/tb_top.sv
// bench for the codec serial port pin logic
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import cspl_pkg::*;
  logic clock_i = 1'b0, nrst_i = 1'b0, strap = 1'b0, wb = 1'b1, sec_in = 1'b0, adc_v = 1'b0;
  logic [15:0] adc = 16'h0000, tx = 16'h0000, rx, dac;
  logic shift_clk, sdi, rdy, dout, rfs, tfs, sfs, soe, ga, gb, txe, rxe, aux, dv;
  int n_fail = 0, n_tests = 0, cyc = 0, k;
  // control word, secondary level, expected a, b, aux
  logic [19:0] rows [4] = '{20'h00000, 20'h0400c, 20'h08103, 20'h0c10f};
  logic [15:0] ws [3] = '{16'hbeef, 16'h0f0f, 16'h7001};
  cspl_top i_cspl_top (.clock_i(clock_i), .nrst_i(nrst_i), .shift_clk_i(shift_clk), .serial_data_in_i(sdi),
    .mode_strap_i(strap), .word_byte_i(wb), .secondary_data_input_i(sec_in), .adc_data_i(adc), .adc_valid_i(adc_v),
    .adc_ready_o(rdy), .serial_data_out_o(dout), .receive_frame_sync_o(rfs), .transmit_frame_sync_o(tfs),
    .secondary_frame_sync_o(sfs), .secondary_frame_sync_oe_o(soe), .general_output_a_o(ga), .general_output_b_o(gb),
    .transmit_end_strobe_n_o(txe), .receive_end_strobe_n_o(rxe), .aux_input_select_o(aux), .dac_data_o(dac),
    .dac_valid_o(dv));
  cspl_dsp_model i_cspl_dsp_model (.tx_word_i(tx), .transmit_frame_sync_i(tfs), .serial_data_out_i(dout),
    .shift_clk_o(shift_clk), .serial_data_in_o(sdi), .rx_word_o(rx));
  initial forever #25 clock_i = ~clock_i;
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // a hang counts as a mismatch
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      conclude();
    end
  end
  task automatic chk(string nm, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // offer held until taken at a rising edge with room
  task automatic push(logic [15:0] w);
    @(negedge clock_i);
    adc = w;
    adc_v = 1'b1;
    do @(posedge clock_i); while (rdy !== 1'b1);
    @(negedge clock_i);
    adc_v = 1'b0;
  endtask
  task automatic waitdv();
    do @(negedge clock_i); while (dv !== 1'b1);
  endtask
  // primary word asking for a control word, then the control word
  task automatic ctrl(logic [15:0] c);
    tx = 16'h8e13;
    push(16'h3c5a);
    waitdv();
    chk("dac_data", dac, 16'h8e13);
    chk("rx_word", rx, 16'h3c5a);
    tx = c;
    @(negedge tfs);
    @(posedge tfs);
    repeat (3) @(negedge clock_i);
  endtask
  initial begin
    repeat (8) @(posedge clock_i);
    chk("reset_pins", {soe, ga, gb, rfs, tfs, sfs, txe, rxe, rdy}, 16'h003f);
    @(negedge clock_i);
    nrst_i = 1'b1;
    repeat (40) @(negedge clock_i);
    for (k = 0; k < 4; k++) begin
      sec_in = rows[k][3];
      ctrl(rows[k][19:4]);
      chk("rx_secondary", rx, {16{rows[k][3]}});
      chk("gen_a_b_aux", {ga, gb, aux}, rows[k][2:0]);
      chk("dual_pins", {txe, rxe, soe}, 16'h0007);
    end
    // reset in mid-run clears the control bits
    nrst_i = 1'b0;
    @(negedge clock_i);
    chk("gen_after_reset", {ga, gb, aux}, 16'h0000);
    nrst_i = 1'b1;
    strap = 1'b1;
    repeat (40) @(negedge clock_i);
    tx = 16'h1234;
    for (k = 0; k < 3; k++) push(ws[k]);
    @(negedge clock_i);
    chk("ready_full", rdy, 16'h0000);
    for (k = 0; k < 3; k++) begin
      waitdv();
      chk("word_strobes", {txe, rxe}, 16'h0000);
      chk("dac_word", dac, 16'h1234);
      chk("rx_word", rx, ws[k]);
    end
    ctrl(16'h0c10);
    chk("word_mode_pins", {ga, gb, aux, soe}, 16'h0002);
    wb = 1'b0;
    repeat (40) @(negedge clock_i);
    tx = 16'h5a3c;
    push(16'hc3a5);
    @(posedge rfs);
    repeat (2) @(negedge clock_i);
    chk("byte_mid", {txe, rxe}, 16'h0000);
    waitdv();
    repeat (2) @(negedge clock_i);
    chk("byte_end", {txe, rxe}, 16'h0003);
    chk("byte_dac", dac, 16'h5a3c);
    chk("byte_rx", rx, 16'hc3a5);
    conclude();
  end
endmodule
`default_nettype wire
